// ==== hw/fp_branch_defs.vh ====
// constants for the floating-point condition branch unit
`ifndef FP_BRANCH_DEFS_VH
`define FP_BRANCH_DEFS_VH
`define OPC_HI          31
`define OPC_LO          26
`define OPC_COP1        6'h11
`define FMT_HI          25
`define FMT_LO          21
`define FMT_BC          5'h08
`define COND_SEL_HI     20
`define COND_SEL_LO     18
`define NULLIFY_SEL_BIT 17
`define TRUE_FALSE_BIT  16
`define OFS_HI          15
`define OFS_LO          0
`define OFS_W           16
`define OFS_SHIFT       2
`define INSN_BYTES      3'h4
`define INSN_STEP_W     3
`define EXC_NONE        2'h0
`define EXC_CPU         2'h1
`define EXC_RI          2'h2
`define ST_IDLE         1'h0
`define ST_SLOT         1'h1
`endif

// ==== hw/fp_condition_branch_unit.v ====
// branch-on-fp-condition decode, resolve and delay-slot control
// What this block does
// - target is sign-extended offset shifted by two, added to delay-slot address.
// - false variants branch only when the selected condition bit is 0.
// - true variants branch only when the selected condition bit is 1.
// - taken branch runs the delay slot first, then fetch continues at target.
// - likely variants nullify the delay slot when not taken, continue sequentially.
// - condition and offset evaluated in branch cycle; effect applied in next slot.
// - one operation steered by true/false and nullify-slot selector bits.
// - coprocessor-unusable or reserved-instruction exception raised when applicable.
// - eight condition bits; the three-bit field selects which one is tested.
// - tested bits are those written by the floating-point compare instruction.
`include "fp_branch_defs.vh"
module fp_condition_branch_unit #(
	parameter REG_W  = 32,
	parameter COND_N = 8
) (
	input  wire              clk_sys_in,
	input  wire              rst_b_in,
	input  wire              insn_valid_in,
	input  wire [31:0]       insn_word_in,
	input  wire [REG_W-1:0]  insn_pc_in,
	input  wire [COND_N-1:0] fp_unit_condition_signal_in,
	input  wire              fp_usable_in,
	input  wire              fp_present_in,
	output reg               branch_seen_out,
	output reg               redirect_out,
	output reg  [REG_W-1:0]  redirect_pc_out,
	output reg               slot_nullify_out,
	output reg  [1:0]        exception_out
);

	localparam [0:0] S_IDLE = `ST_IDLE;
	localparam [0:0] S_SLOT = `ST_SLOT;
	// sign bits needed above the shifted offset
	localparam       EXT_W  = REG_W - `OFS_W - `OFS_SHIFT;
	localparam       STEP_W = `INSN_STEP_W;

	reg              state_q;
	reg              state_d;
	reg              taken_q;
	reg              taken_d;
	reg              likely_q;
	reg              likely_d;
	reg [REG_W-1:0]  target_q;
	reg [REG_W-1:0]  target_d;
	reg              seen_d;
	reg              redirect_d;
	reg [REG_W-1:0]  redirect_pc_d;
	reg              nullify_d;
	reg [1:0]        exception_d;

	wire              is_bc               = insn_word_in[`OPC_HI:`OPC_LO] == `OPC_COP1 &&
	                                        insn_word_in[`FMT_HI:`FMT_LO] == `FMT_BC;
	wire [2:0]        cond_bit_select     = insn_word_in[`COND_SEL_HI:`COND_SEL_LO];
	wire              true_false_select   = insn_word_in[`TRUE_FALSE_BIT];
	wire              nullify_slot_select = insn_word_in[`NULLIFY_SEL_BIT];
	wire [`OFS_W-1:0] ofs                 = insn_word_in[`OFS_HI:`OFS_LO];

	// one-hot pick of the addressed bit; a selector beyond the bit count reads as 0
	wire [COND_N-1:0] sel_onehot = {{(COND_N-1){1'b0}}, 1'b1} << cond_bit_select;
	wire [COND_N-1:0] sel_hit;
	wire              sel_bit    = |sel_hit;
	genvar            gi;
	generate
		for (gi = 0; gi < COND_N; gi = gi + 1) begin : g_cond_lane
			assign sel_hit[gi] = sel_onehot[gi] & fp_unit_condition_signal_in[gi];
		end
	endgenerate

	// selected compare-result bit equals the wanted polarity
	function cond_met;
		input bit_val;
		input want;
		begin
			cond_met = bit_val == want;
		end
	endfunction

	// a missing unit outranks a disabled one
	function [1:0] exc_code;
		input present;
		input usable;
		begin
			if (!present) begin
				exc_code = `EXC_RI;
			end else if (!usable) begin
				exc_code = `EXC_CPU;
			end else begin
				exc_code = `EXC_NONE;
			end
		end
	endfunction

	wire [REG_W-1:0] ofs_ext = {{EXT_W{ofs[`OFS_HI]}}, ofs, {`OFS_SHIFT{1'b0}}};
	wire [REG_W-1:0] slot_pc = insn_pc_in + {{(REG_W-STEP_W){1'b0}}, `INSN_BYTES};
	// a branch in the delay slot is software's fault; it is simply not recognised there
	wire             fire    = insn_valid_in && is_bc && state_q == S_IDLE;
	wire             ok      = fp_present_in && fp_usable_in;

	// next values; the branch is resolved here and acted on one valid slot later
	always @* begin
		state_d       = state_q;
		taken_d       = taken_q;
		likely_d      = likely_q;
		target_d      = target_q;
		seen_d        = fire;
		redirect_d    = 1'b0;
		redirect_pc_d = redirect_pc_out;
		nullify_d     = 1'b0;
		exception_d   = `EXC_NONE;
		case (state_q)
			S_IDLE: begin
				if (fire) begin
					exception_d = exc_code(fp_present_in, fp_usable_in);
					if (ok) begin
						// resolve now, act on the slot that follows
						taken_d  = cond_met(sel_bit, true_false_select);
						likely_d = nullify_slot_select;
						target_d = slot_pc + ofs_ext;
						state_d  = S_SLOT;
					end
				end
			end
			S_SLOT: begin
				// waits for the delay slot to appear; fetch stalls are tolerated
				if (insn_valid_in) begin
					state_d = S_IDLE;
					if (taken_q) begin
						redirect_d    = 1'b1;
						redirect_pc_d = target_q;
					end else if (likely_q) begin
						nullify_d = 1'b1;
					end
				end
			end
			default: begin
				state_d = S_IDLE;
			end
		endcase
	end

	// every output is a flop of its own so fetch never sees decode glitches
	always @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_q <= S_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			taken_q <= 1'b0;
		end else begin
			taken_q <= taken_d;
		end
	end

	always @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			likely_q <= 1'b0;
		end else begin
			likely_q <= likely_d;
		end
	end

	always @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			target_q <= {REG_W{1'b0}};
		end else begin
			target_q <= target_d;
		end
	end

	// flags every decode, excepting ones included
	always @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			branch_seen_out <= 1'b0;
		end else begin
			branch_seen_out <= seen_d;
		end
	end

	always @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			redirect_out <= 1'b0;
		end else begin
			redirect_out <= redirect_d;
		end
	end

	// target stays after the pulse so fetch may pick it up late
	always @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			redirect_pc_out <= {REG_W{1'b0}};
		end else begin
			redirect_pc_out <= redirect_pc_d;
		end
	end

	// squash pulse follows the slot instruction by one cycle
	always @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			slot_nullify_out <= 1'b0;
		end else begin
			slot_nullify_out <= nullify_d;
		end
	end

	// an excepting branch never arms slot tracking, so no redirect follows it
	always @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			exception_out <= `EXC_NONE;
		end else begin
			exception_out <= exception_d;
		end
	end
endmodule

// ==== verification/fp_branch_props.sv ====
// assertions for the fp condition branch unit
module fp_branch_props #(parameter REG_W = 32, parameter COND_N = 8) (
	input wire clk_sys_in, input wire rst_b_in, input wire insn_valid_in,
	input wire [31:0] insn_word_in, input wire [REG_W-1:0] insn_pc_in,
	input wire [COND_N-1:0] fp_unit_condition_signal_in, input wire fp_usable_in, input wire fp_present_in,
	input wire branch_seen_out, input wire redirect_out, input wire [REG_W-1:0] redirect_pc_out,
	input wire slot_nullify_out, input wire [1:0] exception_out);
	timeunit 1ns;
	timeprecision 1ns;
	reg w_q, t_q, n_q;
	reg [REG_W-1:0] p_q;
	// a branch sitting in the slot is never decoded, so w_q gates it
	wire br = insn_valid_in && insn_word_in[31:21] == {6'h11, 5'h08} && !w_q;
	wire ok = fp_present_in && fp_usable_in;
	wire sl = w_q && insn_valid_in;
	always @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			w_q <= 1'b0; t_q <= 1'b0; n_q <= 1'b0; p_q <= {REG_W{1'b0}};
		end else if (br) begin
			w_q <= ok; n_q <= insn_word_in[17];
			t_q <= fp_unit_condition_signal_in[insn_word_in[20:18]] == insn_word_in[16];
			p_q <= insn_pc_in + {{(REG_W-3){1'b0}}, 3'h4} + {{(REG_W-18){insn_word_in[15]}}, insn_word_in[15:0], 2'b00};
		end else if (insn_valid_in) begin
			w_q <= 1'b0;
		end
	end
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_b_in);
	chk_seen_pulse: assert property (br |=> branch_seen_out) else $error("branch not seen");
	chk_taken_target: assert property (sl && t_q |=> redirect_out && redirect_pc_out == $past(p_q))
		else $error("bad redirect");
	chk_false_quiet: assert property (sl && !t_q |=> !redirect_out) else $error("wrong redirect");
	chk_likely_null: assert property (sl && !t_q && n_q |=> slot_nullify_out) else $error("no nullify");
	chk_slot_kept: assert property (sl && (t_q || !n_q) |=> !slot_nullify_out) else $error("bad nullify");
	chk_ri_first: assert property (br && !fp_present_in |=> exception_out == 2'h2) else $error("no ri");
	chk_cpu_unusable: assert property (br && fp_present_in && !fp_usable_in |=> exception_out == 2'h1)
		else $error("no cpu");
	chk_no_exc: assert property (br && ok |=> exception_out == 2'h0 ##1 !branch_seen_out) else $error("exc");
	chk_redir_cause: assert property (redirect_out |-> $past(sl && t_q)) else $error("stray redirect");
	cover property (redirect_out);
	cover property (slot_nullify_out);
	cover property (exception_out == 2'h2);
endmodule
bind fp_condition_branch_unit fp_branch_props #(.REG_W(REG_W), .COND_N(COND_N)) i_props (
	.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .insn_valid_in(insn_valid_in), .insn_word_in(insn_word_in),
	.insn_pc_in(insn_pc_in), .fp_unit_condition_signal_in(fp_unit_condition_signal_in),
	.fp_usable_in(fp_usable_in), .fp_present_in(fp_present_in), .branch_seen_out(branch_seen_out),
	.redirect_out(redirect_out), .redirect_pc_out(redirect_pc_out), .slot_nullify_out(slot_nullify_out),
	.exception_out(exception_out));

// ==== verification/fp_cmp_model.sv ====
// model of the fp compare logic that owns the condition bits
module fp_cmp_model (input wire clk_in, input wire set_in, input wire [2:0] idx_in,
	input wire val_in, output logic [7:0] cond_bits_out);
	timeunit 1ns;
	timeprecision 1ns;
	initial cond_bits_out = 8'h00;
	always @(posedge clk_in) if (set_in) cond_bits_out[idx_in] <= val_in;
endmodule

// ==== verification/tb.sv ====
// self-checking bench for the fp condition branch unit
module tb;
	timeunit 1ns; timeprecision 1ns;
	logic clk_sys_in = 0, rst_b_in = 0, v = 0, u = 1, pr = 1, s = 0, sv = 0, bs, rd, nl;
	logic [2:0] si = 0;
	logic [31:0] w = 0, pc = 0, rp;
	logic [7:0] cond_bits;
	logic [1:0] ex;
	int miscompares = 0, check_count = 0, cyc = 0;
`define CK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; $display("CHECK FAILED %0t bad", $time); end end
	always #20 clk_sys_in = ~clk_sys_in;
	fp_cmp_model i_cond (.clk_in(clk_sys_in), .set_in(s), .idx_in(si), .val_in(sv), .cond_bits_out(cond_bits));
	fp_condition_branch_unit i_dut (.clk_sys_in, .rst_b_in, .insn_valid_in(v), .insn_word_in(w), .insn_pc_in(pc),
		.fp_unit_condition_signal_in(cond_bits), .fp_usable_in(u), .fp_present_in(pr), .branch_seen_out(bs),
		.redirect_out(rd), .redirect_pc_out(rp), .slot_nullify_out(nl), .exception_out(ex));
	task go(input bit t, n, cv, input [2:0] c, input [15:0] o, input [1:0] e);
		bit tk;
		tk = cv == t && e == 0;
		// neighbour bit gets the opposite value so a wrong select shows up
		@(posedge clk_sys_in) begin s <= 1; si <= c ^ 3'h1; sv <= !cv; end
		@(posedge clk_sys_in) begin si <= c; sv <= cv; end
		@(posedge clk_sys_in) begin s <= 0; v <= 1; w <= {6'h11, 5'h08, c, n, t, o}; pc <= 32'h1000; end
		@(posedge clk_sys_in) begin w <= 0; pc <= 32'h1004; end // plain slot instruction
		#1 `CK(ex, e)
		`CK(bs, 1'b1)
		@(posedge clk_sys_in) v <= 0;
		#1 `CK(rd, tk)
		`CK(nl, n && !tk && e == 0)
		if (tk) `CK(rp, 32'h1004 + {{14{o[15]}}, o, 2'b00})
	endtask
	// likely forms run here with their slot nullify checked; real code keeps them rare
	task t_variants;
		for (int i = 0; i < 16; i++) go(i[0], i[1], i[2], i[3:1], i[0] ? 16'hfffe : 16'h7fff, 2'h0);
	endtask
	task t_exc;
		@(posedge clk_sys_in) pr <= 0;
		go(1, 1, 1, 3'h5, 16'h0001, 2'h2);
		@(posedge clk_sys_in) begin pr <= 1; u <= 0; end
		go(0, 1, 0, 3'h2, 16'h0001, 2'h1);
		@(posedge clk_sys_in) u <= 1;
	endtask
	// reset while a likely branch waits for its slot must drop the pending effect
	task t_reset;
		@(posedge clk_sys_in) begin v <= 1; w <= {6'h11, 5'h08, 3'h0, 1'b1, 1'b0, 16'h0004}; pc <= 32'h2000; end
		@(posedge clk_sys_in) begin v <= 0; rst_b_in <= 0; end
		#1 `CK(bs, 1'b0)
		@(posedge clk_sys_in) rst_b_in <= 1;
		@(posedge clk_sys_in) begin v <= 1; w <= 0; pc <= 32'h2004; end
		@(posedge clk_sys_in) v <= 0;
		#1 `CK(rd, 1'b0)
		`CK(nl, 1'b0)
	endtask
	task stop_test;
		$display("checks %0d errors %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge clk_sys_in) if (++cyc > 500) begin miscompares++; stop_test; end
	initial begin
		repeat (20) @(posedge clk_sys_in);
		rst_b_in <= 1;
		t_variants;
		t_exc;
		t_reset;
		stop_test;
	end
endmodule
